// ---- include/motor_gains_pkg.sv ----
/*
  Constants shared by the motor loop gain and drive flag block: object
  indices, subindices, entry counts, presets, flag encodings and widths.
  Assumes a fieldbus stack that passes object accesses as index/subindex.
*/
package motor_gains_pkg;

  localparam int NUM_GAINS = 10;
  localparam int NUM_FLAGS = 3;
  localparam int PWM_W = 12;

  typedef logic [31:0] gain_word_t;
  typedef gain_word_t gain_set_t [NUM_GAINS];
  typedef logic [7:0] flag_t;
  typedef logic [PWM_W-1:0] duty_t;

  localparam logic [15:0] GAIN_SET_INDEX = 16'h3210;
  localparam logic [15:0] FLAG_SET_INDEX = 16'h3212;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_FIRST = 8'h01;
  localparam logic [7:0] GAIN_COUNT = 8'h0a;
  localparam logic [7:0] FLAG_COUNT = 8'h03;

  // Entry positions inside the gain set (subindex minus one)
  localparam int G_POS_P = 0;
  localparam int G_POS_I = 1;
  localparam int G_VEL_P = 2;
  localparam int G_VEL_I = 3;
  localparam int G_FLD_P = 4;
  localparam int G_FLD_I = 5;
  localparam int G_TRQ_P = 6;
  localparam int G_TRQ_I = 7;
  localparam int G_OL_P = 8;
  localparam int G_OL_I = 9;

  // Entry positions inside the flag set
  localparam int F_POWER = 0;
  localparam int F_FIELD = 1;
  localparam int F_KEEP = 2;

  localparam gain_set_t GAIN_PRESET = '{
    32'h00000800, 32'h00000000, 32'h00002ee0, 32'h0000001e,
    32'h000668a0, 32'h00002ee0, 32'h000668a0, 32'h00002ee0,
    32'h0003a980, 32'h0000afc8
  };

  localparam flag_t FLAG_PRESET = 8'h00;
  localparam flag_t FLAG_OFF = 8'h00;
  localparam flag_t FLAG_ON = 8'h01;
  localparam flag_t FLAG_NEG = 8'hff;

  localparam duty_t DUTY_HALF = 12'h800;
  localparam duty_t DUTY_RESET = 12'h800;

endpackage

// ---- design/reset_sync.sv ----
/*
  Two-stage release synchroniser for the active-low reset.
  Assumes reset_n may drop at any time; release is aligned to clk.
*/
`timescale 1ns/100ps
module reset_sync (
  input wire logic clk,
  input wire logic reset_n,
  output logic rstSync_n
);

  logic stage1_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_q <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      stage1_q <= 1'b1;
      rstSync_n <= stage1_q;
    end
  end

endmodule // reset_sync

// ---- design/motor_loop_gains.sv ----
/*
  Loop gain set and drive flag set of a motor drive controller, reached
  through object-dictionary accesses (index, subindex, data), plus the
  standstill PWM select, rotating-field direction and auto setup loading.
  Assumes the fieldbus stack issues one-cycle requests on clk and that
  the power state machine, control loops and setup sequencer sit outside.
  // Function
  // [RULE_01] Position gains: P preset 0x800, I zero
  // [RULE_02] Velocity gains preset 0x2ee0 and 0x1e
  // [RULE_03] Field current gains preset 0x668a0, 0x2ee0
  // [RULE_04] Torque current gains preset 0x668a0, 0x2ee0
  // [RULE_05] Separate open-loop current gains 0x3a980, 0xafc8
  // [RULE_06] Power flag 0: half duty when on
  // [RULE_07] Power flag 1: controller drives PWM
  // [RULE_08] Field override: 0 default, 1 positive, -1 negative
  // [RULE_09] Field override applies only after restart
  // [RULE_10] Keep flag 0: setup loads motor-type gains
  // [RULE_11] Keep flag 1: setup leaves gains untouched
  // [RULE_12] Counts read ten and three; flags preset zero
  // [RULE_13] Open loop uses only current controller
  // [RULE_14] Count entries refuse writes, read fixed
  // [RULE_15] Reset loads every preset before use
*/
`timescale 1ns/100ps
module motor_loop_gains #(
  // Preset sets loaded by auto setup; plain defaults equal to the presets
  parameter motor_gains_pkg::gain_set_t STEPPER_GAINS = motor_gains_pkg::GAIN_PRESET,
  parameter motor_gains_pkg::gain_set_t BLDC_GAINS = motor_gains_pkg::GAIN_PRESET
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic odReq,
  input wire logic odWrite,
  input wire logic [15:0] odIndex,
  input wire logic [7:0] odSubindex,
  input wire logic [31:0] odWdata,
  output logic odAck,
  output logic odAbort,
  output logic [31:0] odRdata,
  input wire logic powerSwitchedOn,
  input wire logic [motor_gains_pkg::PWM_W-1:0] controllerDuty,
  output logic [motor_gains_pkg::PWM_W-1:0] pwmDuty,
  input wire logic controllerRestart,
  output logic fieldForced,
  output logic fieldInvert,
  output logic setupPending,
  input wire logic autoSetupStart,
  input wire logic motorIsStepperPin,
  output logic autoSetupDone,
  input wire logic openLoop,
  output logic currentLoopOnly,
  output logic [31:0] posPropGain,
  output logic [31:0] posIntGain,
  output logic [31:0] velPropGain,
  output logic [31:0] velIntGain,
  output logic [31:0] field_current_prop_gain,
  output logic [31:0] field_current_integral_gain,
  output logic [31:0] torque_current_prop_gain,
  output logic [31:0] torque_current_integral_gain,
  output logic [31:0] openloopPropGain,
  output logic [31:0] openloopIntGain
);

  logic rstN;
  motor_gains_pkg::gain_word_t gain_q [motor_gains_pkg::NUM_GAINS];
  motor_gains_pkg::flag_t flag_q [motor_gains_pkg::NUM_FLAGS];
  logic [2:0] typeSync_q;
  logic motorStepper_q;

  reset_sync u_reset_sync (
    .clk(clk),
    .reset_n(reset_n),
    .rstSync_n(rstN)
  );

  function automatic logic subInRange(input logic [7:0] sub, input logic [7:0] last);
    subInRange = (sub >= motor_gains_pkg::SUB_FIRST) && (sub <= last);
  endfunction

  // Object decode
  wire gainObj = (odIndex == motor_gains_pkg::GAIN_SET_INDEX);
  wire flagObj = (odIndex == motor_gains_pkg::FLAG_SET_INDEX);
  wire countSub = (odSubindex == motor_gains_pkg::SUB_COUNT);
  wire gainEntry = gainObj && subInRange(odSubindex, motor_gains_pkg::GAIN_COUNT);
  wire flagEntry = flagObj && subInRange(odSubindex, motor_gains_pkg::FLAG_COUNT);
  wire known = ((gainObj || flagObj) && countSub) || gainEntry || flagEntry;
  wire [7:0] entryIdx = odSubindex - motor_gains_pkg::SUB_FIRST;
  wire gainWr = odReq && odWrite && gainEntry;
  wire flagWr = odReq && odWrite && flagEntry;
  // [RULE_14] refuse count writes
  wire abortNow = odReq && (!known || (odWrite && countSub));

  wire [31:0] gainRd = gain_q[entryIdx[3:0]];
  wire [31:0] flagRd = {{24{flag_q[entryIdx[1:0]][7]}}, flag_q[entryIdx[1:0]]};
  // [RULE_12] fixed entry counts
  wire [31:0] countRd = gainObj ? {24'h000000, motor_gains_pkg::GAIN_COUNT}
                                : {24'h000000, motor_gains_pkg::FLAG_COUNT};
  wire [31:0] readMux = countSub ? countRd : (gainEntry ? gainRd : flagRd);

  // Pin synchroniser: the first stage is only read by the second
  wire typeAgree = (typeSync_q[1] == typeSync_q[2]);
  wire motorStepperNext = typeAgree ? typeSync_q[2] : motorStepper_q;

  // Setup load wins over a same-cycle fieldbus write so a set is never mixed
  wire keepGains = (flag_q[motor_gains_pkg::F_KEEP] == motor_gains_pkg::FLAG_ON);
  // [RULE_10] motor-type set load
  wire setupLoad = autoSetupStart && !keepGains;

  // [RULE_06] half duty when switched on
  wire legacyPower = (flag_q[motor_gains_pkg::F_POWER] == motor_gains_pkg::FLAG_ON);
  wire [motor_gains_pkg::PWM_W-1:0] dutyNext =
    (powerSwitchedOn && !legacyPower) ? motor_gains_pkg::DUTY_HALF : controllerDuty;

  // [RULE_08] direction decode
  wire [7:0] fieldReq = flag_q[motor_gains_pkg::F_FIELD];
  wire forceNext = (fieldReq == motor_gains_pkg::FLAG_ON) ||
                   (fieldReq == motor_gains_pkg::FLAG_NEG);
  wire invertNext = (fieldReq == motor_gains_pkg::FLAG_NEG);

  // [RULE_15] presets on reset
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < motor_gains_pkg::NUM_GAINS; i++) begin
        gain_q[i] <= motor_gains_pkg::GAIN_PRESET[i];
      end
    end else begin
      for (int i = 0; i < motor_gains_pkg::NUM_GAINS; i++) begin
        if (setupLoad) begin
          gain_q[i] <= motorStepper_q ? STEPPER_GAINS[i] : BLDC_GAINS[i];
        end else if (gainWr && (entryIdx[3:0] == 4'(i))) begin
          gain_q[i] <= odWdata;
        end
      end
    end
  end

  // [RULE_12] flags preset zero
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < motor_gains_pkg::NUM_FLAGS; i++) begin
        flag_q[i] <= motor_gains_pkg::FLAG_PRESET;
      end
    end else begin
      for (int i = 0; i < motor_gains_pkg::NUM_FLAGS; i++) begin
        if (flagWr && (entryIdx[1:0] == 2'(i))) begin
          flag_q[i] <= odWdata[7:0];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      odAck <= 1'b0;
      odAbort <= 1'b0;
      odRdata <= 32'h00000000;
    end else begin
      odAck <= odReq && !abortNow;
      odAbort <= abortNow;
      odRdata <= (odReq && !odWrite && known) ? readMux : 32'h00000000;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      typeSync_q <= 3'h0;
      motorStepper_q <= 1'b0;
    end else begin
      typeSync_q <= {typeSync_q[1:0], motorIsStepperPin};
      motorStepper_q <= motorStepperNext;
    end
  end

  // [RULE_07] controller duty passes
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pwmDuty <= motor_gains_pkg::DUTY_RESET;
    end else begin
      pwmDuty <= dutyNext;
    end
  end

  // [RULE_09] direction latched at restart
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      fieldForced <= 1'b0;
      fieldInvert <= 1'b0;
      setupPending <= 1'b0;
    end else begin
      if (controllerRestart) begin
        fieldForced <= forceNext;
        fieldInvert <= invertNext;
      end
      // A restart in the same cycle as setup start leaves setup owed
      setupPending <= controllerRestart || (setupPending && !autoSetupStart);
    end
  end

  // [RULE_13] open loop current only
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      autoSetupDone <= 1'b0;
      currentLoopOnly <= 1'b0;
    end else begin
      autoSetupDone <= autoSetupStart;
      currentLoopOnly <= openLoop;
    end
  end

  // [RULE_01] position gains
  assign posPropGain = gain_q[motor_gains_pkg::G_POS_P];
  assign posIntGain = gain_q[motor_gains_pkg::G_POS_I];
  // [RULE_02] velocity gains
  assign velPropGain = gain_q[motor_gains_pkg::G_VEL_P];
  assign velIntGain = gain_q[motor_gains_pkg::G_VEL_I];
  // [RULE_03] field current gains
  assign field_current_prop_gain = gain_q[motor_gains_pkg::G_FLD_P];
  assign field_current_integral_gain = gain_q[motor_gains_pkg::G_FLD_I];
  // [RULE_04] torque current gains
  assign torque_current_prop_gain = gain_q[motor_gains_pkg::G_TRQ_P];
  assign torque_current_integral_gain = gain_q[motor_gains_pkg::G_TRQ_I];
  // [RULE_05] open-loop current gains
  assign openloopPropGain = gain_q[motor_gains_pkg::G_OL_P];
  assign openloopIntGain = gain_q[motor_gains_pkg::G_OL_I];

  property p_preset_after_reset;
    @(posedge clk) $rose(rstN) |->
      (posPropGain == 32'h00000800) && (posIntGain == 32'h00000000) &&
      (velPropGain == 32'h00002ee0) && (velIntGain == 32'h0000001e) &&
      (field_current_prop_gain == 32'h000668a0) &&
      (torque_current_integral_gain == 32'h00002ee0) &&
      (openloopPropGain == 32'h0003a980) && (openloopIntGain == 32'h0000afc8);
  endproperty
  a_preset_after_reset: assert property (p_preset_after_reset) // [RULE_15]
    else $error("gain preset missing after reset");

  property p_pos_write;
    @(posedge clk) disable iff (!rstN)
      (odReq && odWrite && gainObj && (odSubindex == 8'h01) && !autoSetupStart)
      |=> (posPropGain == $past(odWdata)) && odAck;
  endproperty
  a_pos_write: assert property (p_pos_write) // [RULE_01]
    else $error("position gain write not stored");

  property p_count_read;
    @(posedge clk) disable iff (!rstN)
      (odReq && !odWrite && countSub && (gainObj || flagObj))
      |=> odRdata == (($past(gainObj)) ? 32'h0000000a : 32'h00000003);
  endproperty
  a_count_read: assert property (p_count_read) // [RULE_12]
    else $error("entry count read wrong");

  property p_count_write_refused;
    @(posedge clk) disable iff (!rstN)
      (odReq && odWrite && countSub && gainObj) |=> odAbort && !odAck;
  endproperty
  a_count_write_refused: assert property (p_count_write_refused) // [RULE_14]
    else $error("count write not refused");

  property p_half_duty;
    @(posedge clk) disable iff (!rstN)
      (powerSwitchedOn && (flag_q[motor_gains_pkg::F_POWER] == 8'h00))
      |=> pwmDuty == 12'h800;
  endproperty
  a_half_duty: assert property (p_half_duty) // [RULE_06]
    else $error("duty not held at half");

  property p_ctrl_duty;
    @(posedge clk) disable iff (!rstN)
      (powerSwitchedOn && (flag_q[motor_gains_pkg::F_POWER] == 8'h01))
      |=> pwmDuty == $past(controllerDuty);
  endproperty
  a_ctrl_duty: assert property (p_ctrl_duty) // [RULE_07]
    else $error("controller duty not passed");

  property p_field_negative;
    @(posedge clk) disable iff (!rstN)
      (controllerRestart && (fieldReq == 8'hff)) |=> fieldForced && fieldInvert;
  endproperty
  a_field_negative: assert property (p_field_negative) // [RULE_08]
    else $error("inverted field not forced");

  property p_field_waits_restart;
    @(posedge clk) disable iff (!rstN)
      !controllerRestart |=> $stable(fieldInvert) && $stable(fieldForced);
  endproperty
  a_field_waits_restart: assert property (p_field_waits_restart) // [RULE_09]
    else $error("field direction changed without restart");

  property p_setup_load;
    @(posedge clk) disable iff (!rstN)
      (autoSetupStart && !keepGains && motorStepper_q)
      |=> (velPropGain == STEPPER_GAINS[motor_gains_pkg::G_VEL_P]) && autoSetupDone;
  endproperty
  a_setup_load: assert property (p_setup_load) // [RULE_10]
    else $error("stepper gain set not loaded");

  property p_setup_keep;
    @(posedge clk) disable iff (!rstN)
      (autoSetupStart && keepGains && !odReq)
      |=> (velPropGain == $past(velPropGain)) && (openloopIntGain == $past(openloopIntGain));
  endproperty
  a_setup_keep: assert property (p_setup_keep) // [RULE_11]
    else $error("kept gains modified by setup");

  property p_open_loop;
    @(posedge clk) disable iff (!rstN)
      openLoop[*2] |-> currentLoopOnly;
  endproperty
  a_open_loop: assert property (p_open_loop) // [RULE_13]
    else $error("open loop not flagged");

endmodule // motor_loop_gains

// ---- testbench/od_master.sv ----
/*
  Fieldbus master model: one object access per call, one-cycle request.
  Assumes the block answers on the cycle after the edge that takes it.
*/
`timescale 1ns/100ps
module od_master (
  input wire logic clk,
  output logic odReq,
  output logic odWrite,
  output logic [15:0] odIndex,
  output logic [7:0] odSubindex,
  output logic [31:0] odWdata,
  input wire logic odAck,
  input wire logic odAbort,
  input wire logic [31:0] odRdata
);
  initial begin
    odReq = 1'b0;
    odWrite = 1'b0;
    odIndex = 16'h0000;
    odSubindex = 8'h00;
    odWdata = 32'h00000000;
  end

  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
      input logic [31:0] data, output logic ack, output logic abort, output logic [31:0] rd);
    @(negedge clk);
    odReq = 1'b1;
    odWrite = wr;
    odIndex = idx;
    odSubindex = sub;
    odWdata = data;
    @(negedge clk);
    ack = odAck;
    abort = odAbort;
    rd = odRdata;
    odReq = 1'b0;
    // Released lines carry no stale value the block could lean on
    odWrite = ~wr;
    odIndex = ~idx;
    odSubindex = ~sub;
    odWdata = ~data;
  endtask
endmodule // od_master

// ---- testbench/motor_loop_gains_and_drive_flags_tb.sv ----
/*
  Testbench of the loop gain and drive flag block: object accesses through
  the master model, drive, field and setup inputs driven at falling edges.
  Assumes the package constants and a single 250 MHz clock.
*/
`timescale 1ns/100ps
module motor_loop_gains_and_drive_flags_tb;
  localparam logic [15:0] GI = motor_gains_pkg::GAIN_SET_INDEX;
  localparam logic [15:0] FI = motor_gains_pkg::FLAG_SET_INDEX;
  localparam motor_gains_pkg::gain_set_t STEP = '{default: 32'h00005a5a};
  localparam motor_gains_pkg::gain_set_t PRE = motor_gains_pkg::GAIN_PRESET;
  logic clk = 1'b0, reset_n = 1'b0, odReq, odWrite, odAck, odAbort;
  logic [15:0] odIndex;
  logic [7:0] odSubindex;
  logic [31:0] odWdata, odRdata, g [10];
  logic powerSwitchedOn = 1'b1, controllerRestart = 1'b0, autoSetupStart = 1'b0;
  logic motorIsStepperPin = 1'b1, openLoop = 1'b0;
  logic fieldForced, fieldInvert, setupPending, autoSetupDone, currentLoopOnly;
  logic [11:0] controllerDuty = 12'h123, pwmDuty;
  motor_gains_pkg::gain_set_t wv;
  int errCount = 0, nTests = 0;

  always #2 clk = ~clk;

  od_master m (.clk(clk), .odReq(odReq), .odWrite(odWrite), .odIndex(odIndex),
    .odSubindex(odSubindex), .odWdata(odWdata), .odAck(odAck), .odAbort(odAbort),
    .odRdata(odRdata));

  motor_loop_gains #(.STEPPER_GAINS(STEP)) dut (.clk(clk), .reset_n(reset_n),
    .odReq(odReq), .odWrite(odWrite), .odIndex(odIndex), .odSubindex(odSubindex),
    .odWdata(odWdata), .odAck(odAck), .odAbort(odAbort), .odRdata(odRdata),
    .powerSwitchedOn(powerSwitchedOn), .controllerDuty(controllerDuty), .pwmDuty(pwmDuty),
    .controllerRestart(controllerRestart), .fieldForced(fieldForced),
    .fieldInvert(fieldInvert), .setupPending(setupPending), .autoSetupStart(autoSetupStart),
    .motorIsStepperPin(motorIsStepperPin), .autoSetupDone(autoSetupDone),
    .openLoop(openLoop), .currentLoopOnly(currentLoopOnly), .posPropGain(g[0]),
    .posIntGain(g[1]), .velPropGain(g[2]), .velIntGain(g[3]),
    .field_current_prop_gain(g[4]), .field_current_integral_gain(g[5]),
    .torque_current_prop_gain(g[6]), .torque_current_integral_gain(g[7]),
    .openloopPropGain(g[8]), .openloopIntGain(g[9]));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
      input logic ok);
    logic a, b;
    logic [31:0] r;
    m.access(1'b1, idx, sub, d, a, b, r);
    chk("write answer", ok ? 32'h1 : 32'h2, {30'h0, b, a});
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] e);
    logic a, b;
    logic [31:0] r;
    m.access(1'b0, idx, sub, 32'h0, a, b, r);
    chk("read answer", 32'h1, {30'h0, b, a});
    chk("read data", e, r);
  endtask

  // Every entry read back, and each gain port showing the same value
  task automatic rdGains(input motor_gains_pkg::gain_set_t e);
    for (int i = 0; i < 10; i++) begin
      rd(GI, 8'(i + 1), e[i]);
      chk("gain port", e[i], g[i]);
    end
  endtask

  task automatic pulse(input int which);
    @(negedge clk);
    if (which == 0) controllerRestart = 1'b1;
    else autoSetupStart = 1'b1;
    @(negedge clk);
    controllerRestart = 1'b0;
    autoSetupStart = 1'b0;
  endtask

  task automatic wrapUp();
    if (errCount == 0 && nTests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #8000;
    errCount++;
    wrapUp();
  end

  initial begin
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    rdGains(PRE);
    chk("currentLoopOnly idle", 32'h0, {31'h0, currentLoopOnly});
    rd(GI, 8'h00, 32'h0000000a);
    rd(FI, 8'h00, 32'h00000003);
    for (int i = 1; i < 4; i++) rd(FI, 8'(i), 32'h0);
    chk("pwm flag 0", 32'h800, {20'h0, pwmDuty});
    wr(GI, 8'h00, 32'h00000055, 1'b0);
    wr(FI, 8'h00, 32'h00000055, 1'b0);
    rd(GI, 8'h00, 32'h0000000a);
    rd(FI, 8'h00, 32'h00000003);
    wr(GI, 8'h0b, 32'h1, 1'b0);
    wr(FI, 8'h04, 32'h1, 1'b0);
    for (int i = 0; i < 10; i++) wv[i] = 32'h10000000 | i;
    for (int i = 0; i < 10; i++) wr(GI, 8'(i + 1), wv[i], 1'b1);
    rdGains(wv);
    wr(FI, 8'h01, 32'h1, 1'b1);
    repeat (2) @(negedge clk);
    chk("pwm flag 1", 32'h123, {20'h0, pwmDuty});
    wr(FI, 8'h01, 32'h0, 1'b1);
    repeat (2) @(negedge clk);
    chk("pwm flag 0", 32'h800, {20'h0, pwmDuty});
    powerSwitchedOn = 1'b0;
    repeat (2) @(negedge clk);
    chk("pwm not switched on", 32'h123, {20'h0, pwmDuty});
    wr(FI, 8'h02, 32'h000000ff, 1'b1);
    rd(FI, 8'h02, 32'hffffffff);
    chk("field before restart", 32'h0, {30'h0, fieldForced, fieldInvert});
    pulse(0);
    chk("field negative", 32'h3, {30'h0, fieldForced, fieldInvert});
    chk("autoSetupDone idle", 32'h0, {31'h0, autoSetupDone});
    chk("setupPending", 32'h1, {31'h0, setupPending});
    wr(FI, 8'h02, 32'h00000001, 1'b1);
    pulse(0);
    chk("field positive", 32'h2, {30'h0, fieldForced, fieldInvert});
    wr(FI, 8'h02, 32'h00000000, 1'b1);
    pulse(0);
    chk("field default", 32'h0, {30'h0, fieldForced, fieldInvert});
    wr(FI, 8'h03, 32'h1, 1'b1);
    pulse(1);
    chk("setupPending cleared", 32'h0, {31'h0, setupPending});
    chk("autoSetupDone", 32'h1, {31'h0, autoSetupDone});
    rdGains(wv);
    wr(FI, 8'h03, 32'h0, 1'b1);
    pulse(1);
    rdGains(STEP);
    motorIsStepperPin = 1'b0;
    repeat (6) @(negedge clk);
    pulse(1);
    rdGains(motor_gains_pkg::GAIN_PRESET);
    openLoop = 1'b1;
    repeat (2) @(negedge clk);
    chk("currentLoopOnly", 32'h1, {31'h0, currentLoopOnly});
    wrapUp();
  end
endmodule // motor_loop_gains_and_drive_flags_tb
